// *** core/sesq_top.sv ***
// Behaviour
// RULE_01 - Talk address mid-message flushes both buffers, sets query error.
// RULE_02 - Listen address mid-response flushes the output, sets query error.
// RULE_03 - A new program message while a response is unread drops it.
// RULE_04 - Query at full 256-byte queue flushes, restarts, sets query error.
// RULE_05 - The status query returns the register value and then clears it.
// RULE_06 - No external write can set event status bits, only clear them.
// RULE_07 - The clear-status command clears the event status register.
// RULE_08 - With the flag true, power-on clears then records the power event.
// RULE_09 - The enable query returns the enable register and keeps it.
// RULE_10 - An enable write loads the bits whose weights sum to its value.
// RULE_11 - An enable write of zero clears the enable register.
// RULE_12 - Power-on clears the enable if the flag is true or has no command.
// RULE_13 - Enable survives device clear, reset and clear-status commands.
// RULE_14 - Events sit at bits 7, 5, 4, 3, 2 and 0; bits 6 and 1 read zero.
// RULE_15 - The OR of set and enabled bits drives the summary bit.
// RULE_16 - Bits latch until cleared, so coincident events are all kept.
`timescale 1ns/1ps
`default_nettype none
`include "sesq_map.svh"

module sesq_top
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    powerOn,
  input  wire logic                    pscFlag,
  input  wire logic                    pscImpl,
  input  wire sesq_pkg::sesq_event_type evIn,
  input  wire logic                    progByte,
  input  wire logic                    progTerm,
  input  wire logic                    respByte,
  input  wire logic                    respTerm,
  input  wire logic                    talkAddr,
  input  wire logic                    listenAddr,
  input  wire logic                    queryRx,
  input  wire logic [8:0]              outLevel,
  input  wire logic                    clsCmd,
  input  wire logic                    esrQuery,
  input  wire logic                    eseQuery,
  input  wire logic                    eseWrite,
  input  wire logic [7:0]              eseValue,
  output logic [7:0]                   respData,
  output logic                         respValid,
  output logic                         inFlush,
  output logic                         outFlush,
  output logic                         respRestart,
  output logic                         esbSummary,
  output logic [7:0]                   esrView
);

  sesq_pkg::sesq_state_type st_ff;
  sesq_pkg::sesq_state_type nxt_st;

  logic [7:0] setVec;
  logic       clrEsr;
  logic       abortProg;
  logic       abortResp;
  logic       dropResp;
  logic       overflow;
  logic       pwrRise;

  // Builds a one-hot byte for an event position
  function automatic logic [7:0] bitOf(input int pos);
    logic [7:0] v;
    v = 8'h00;
    v[pos[2:0]] = 1'b1;
    return v;
  endfunction : bitOf

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;

    // Power pin crosses in through two flops before edge detection
    nxt_st.pwrS1 = powerOn;
    nxt_st.pwrS2 = st_ff.pwrS1;
    nxt_st.pwrS3 = st_ff.pwrS2;
    pwrRise = st_ff.pwrS2 & ~st_ff.pwrS3;

    // Query error causes, and the unread-response drop, which sets no error
    abortProg = talkAddr & st_ff.progRx; // RULE_01
    abortResp = listenAddr & st_ff.respTx; // RULE_02
    dropResp = progByte & ~st_ff.progRx
             & (outLevel != `SESQ_OQ_EMPTY); // RULE_03
    overflow = queryRx & (outLevel == `SESQ_OQ_DEPTH); // RULE_04

    // Event bits set this cycle; bits 6 and 1 never appear
    setVec = 8'h00;
    if (evIn.cmdErr)
      setVec = setVec | bitOf(`SESQ_BIT_CME); // RULE_14
    if (evIn.exeErr)
      setVec = setVec | bitOf(`SESQ_BIT_EXE);
    if (evIn.devErr)
      setVec = setVec | bitOf(`SESQ_BIT_DDE);
    if (evIn.opDone)
      setVec = setVec | bitOf(`SESQ_BIT_OPC);
    if (abortProg | abortResp | overflow)
      setVec = setVec | bitOf(`SESQ_BIT_QYE); // RULE_01 RULE_02 RULE_04
    if (st_ff.phase == sesq_pkg::SESQ_PSET)
      setVec = setVec | bitOf(`SESQ_BIT_PON); // RULE_08

    // Clearing actions; software has no path that sets a bit
    clrEsr = clsCmd | esrQuery // RULE_05 RULE_07
           | ((st_ff.phase == sesq_pkg::SESQ_PCLR) & pscFlag); // RULE_08

    // Set wins over clear so an event in the clearing cycle survives
    nxt_st.standard_event_status = ((clrEsr ? `SESQ_ESR_RST : st_ff.standard_event_status) | setVec)
               & `SESQ_ESR_MASK; // RULE_06 RULE_16 RULE_14

    // Enable register: only its own command and power-on touch it
    if ((st_ff.phase == sesq_pkg::SESQ_PCLR) & (pscFlag | ~pscImpl))
      nxt_st.standard_event_enable = `SESQ_ESE_RST; // RULE_12
    else if (eseWrite)
      nxt_st.standard_event_enable = eseValue; // RULE_10 RULE_11
    // Clear-status deliberately absent here // RULE_13

    // Power-on sequence: clear first where the flags call for it, then record the power event
    unique case (st_ff.phase)
      sesq_pkg::SESQ_RUN:
      begin
        if (pwrRise)
          nxt_st.phase = sesq_pkg::SESQ_PCLR;
      end
      sesq_pkg::SESQ_PCLR:
      begin
        nxt_st.phase = sesq_pkg::SESQ_PSET; // RULE_08
      end
      sesq_pkg::SESQ_PSET:
      begin
        nxt_st.phase = sesq_pkg::SESQ_RUN;
      end
      default:
      begin
        nxt_st.phase = sesq_pkg::SESQ_RUN;
      end
    endcase

    // Program message tracking; talk abort wins over new bytes
    if (abortProg | progTerm)
      nxt_st.progRx = 1'b0; // RULE_01
    else if (progByte)
      nxt_st.progRx = 1'b1;

    // Response tracking; listen abort, drop or overflow ends the response in progress
    if (abortResp | dropResp | overflow | respTerm)
      nxt_st.respTx = 1'b0; // RULE_02 RULE_03
    else if (respByte)
      nxt_st.respTx = 1'b1;

    // Flush and restart strobes, one cycle each
    nxt_st.inFlush = abortProg; // RULE_01
    nxt_st.outFlush = abortProg | abortResp
                    | dropResp | overflow; // RULE_02 RULE_03 RULE_04
    nxt_st.respRestart = abortResp | dropResp | overflow; // RULE_04

    // Query answers carry the plain binary value; the formatter
    // turns it into decimal text, so no divider is spent here
    nxt_st.respValid = esrQuery | eseQuery;
    if (esrQuery)
      nxt_st.respData = st_ff.standard_event_status & `SESQ_ESR_MASK; // RULE_05
    else if (eseQuery)
      nxt_st.respData = st_ff.standard_event_enable; // RULE_09

    // Summary is formed from next values so it tracks the registers
    nxt_st.esbSum = |(nxt_st.standard_event_status & nxt_st.standard_event_enable); // RULE_15
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign respData    = st_ff.respData;
  assign respValid   = st_ff.respValid;
  assign inFlush     = st_ff.inFlush;
  assign outFlush    = st_ff.outFlush;
  assign respRestart = st_ff.respRestart;
  assign esbSummary  = st_ff.esbSum;
  assign esrView     = st_ff.standard_event_status;

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (rst);

  // Talk abort flushes both buffers and flags the error
  property p_abort_talk;
    talkAddr && st_ff.progRx
      |=> st_ff.inFlush && st_ff.outFlush && st_ff.standard_event_status[2] && !st_ff.progRx;
  endproperty
  a_abort_talk: assert property (p_abort_talk) // RULE_01
    else $error("talk abort not handled");

  // Listen abort stops the response and flags the error
  property p_abort_listen;
    listenAddr && st_ff.respTx
      |=> st_ff.outFlush && st_ff.standard_event_status[2] && !st_ff.respTx && !st_ff.inFlush;
  endproperty
  a_abort_listen: assert property (p_abort_listen) // RULE_02
    else $error("listen abort not handled");

  // Unread response dropped on a fresh message
  property p_drop_unread;
    progByte && !st_ff.progRx && outLevel != 9'h000 && !queryRx
      |=> st_ff.outFlush && st_ff.respRestart;
  endproperty
  a_drop_unread: assert property (p_drop_unread) // RULE_03
    else $error("unread response kept");

  // Full queue plus query
  property p_overflow;
    queryRx && outLevel == 9'h100
      |=> st_ff.outFlush && st_ff.respRestart && st_ff.standard_event_status[2];
  endproperty
  a_overflow: assert property (p_overflow) // RULE_04
    else $error("overflow not handled");

  // Destructive read returns old value then zero
  sequence s_esr_read;
    esrQuery && setVec == 8'h00;
  endsequence
  property p_esr_read;
    s_esr_read |=> st_ff.respValid
      && st_ff.respData == $past(st_ff.standard_event_status) && st_ff.standard_event_status == 8'h00;
  endproperty
  a_esr_read: assert property (p_esr_read) // RULE_05
    else $error("status read wrong");

  // New ones only from hardware events
  property p_no_ext_set;
    ##1 (st_ff.standard_event_status & ~$past(st_ff.standard_event_status) & ~$past(setVec)) == 8'h00;
  endproperty
  a_no_ext_set: assert property (p_no_ext_set) // RULE_06
    else $error("status bit set without event");

  // Clear-status empties the register
  property p_cls;
    clsCmd && setVec == 8'h00 |=> st_ff.standard_event_status == 8'h00;
  endproperty
  a_cls: assert property (p_cls) // RULE_07
    else $error("clear status failed");

  // Power-on: cleared, then power bit set as the phase returns to running
  sequence s_pon_clear;
    st_ff.phase == sesq_pkg::SESQ_PCLR && pscFlag && setVec == 8'h00;
  endsequence
  sequence s_pon_then_set;
    st_ff.standard_event_status == 8'h00 ##1 st_ff.standard_event_status[7]
      && st_ff.phase == sesq_pkg::SESQ_RUN;
  endsequence
  property p_pon;
    s_pon_clear |=> s_pon_then_set;
  endproperty
  a_pon: assert property (p_pon) // RULE_08
    else $error("power-on sequence wrong");

  // Enable query leaves the enable register alone
  property p_ese_query;
    eseQuery && !esrQuery && !eseWrite
      && st_ff.phase == sesq_pkg::SESQ_RUN
      |=> st_ff.respValid && st_ff.respData == $past(st_ff.standard_event_enable)
      && $stable(st_ff.standard_event_enable);
  endproperty
  a_ese_query: assert property (p_ese_query) // RULE_09
    else $error("enable query wrong");

  // Enable write loads the pattern
  property p_ese_write;
    eseWrite && st_ff.phase != sesq_pkg::SESQ_PCLR
      |=> st_ff.standard_event_enable == $past(eseValue);
  endproperty
  a_ese_write: assert property (p_ese_write) // RULE_10
    else $error("enable write not loaded");

  // Zero write clears
  property p_ese_zero;
    eseWrite && eseValue == 8'h00 |=> st_ff.standard_event_enable == 8'h00;
  endproperty
  a_ese_zero: assert property (p_ese_zero) // RULE_11
    else $error("enable zero write failed");

  // Power-on clear of the enable register
  property p_ese_pon;
    st_ff.phase == sesq_pkg::SESQ_PCLR && (pscFlag || !pscImpl)
      |=> st_ff.standard_event_enable == 8'h00;
  endproperty
  a_ese_pon: assert property (p_ese_pon) // RULE_12
    else $error("enable not cleared at power-on");

  // Clear-status keeps the enable register
  property p_ese_keep;
    clsCmd && !eseWrite && st_ff.phase == sesq_pkg::SESQ_RUN
      |=> $stable(st_ff.standard_event_enable);
  endproperty
  a_ese_keep: assert property (p_ese_keep) // RULE_13
    else $error("enable lost on clear status");

  // Unused bits never set
  property p_unused_bits;
    !st_ff.standard_event_status[6] && !st_ff.standard_event_status[1];
  endproperty
  a_unused_bits: assert property (p_unused_bits) // RULE_14
    else $error("unused status bit set");

  // Summary follows set and enabled bits
  property p_summary;
    st_ff.esbSum == |(st_ff.standard_event_status & st_ff.standard_event_enable);
  endproperty
  a_summary: assert property (p_summary) // RULE_15
    else $error("summary mismatch");

  // Bits stay set until a clearing action
  property p_sticky;
    !clrEsr |=> ($past(st_ff.standard_event_status) & ~st_ff.standard_event_status) == 8'h00;
  endproperty
  a_sticky: assert property (p_sticky) // RULE_16
    else $error("status bit lost");

endmodule : sesq_top

`default_nettype wire

// *** core/sesq_map.svh ***
`ifndef SESQ_MAP_SVH
`define SESQ_MAP_SVH

// Event bit positions of the standard event status register
`define SESQ_BIT_PON 7
`define SESQ_BIT_CME 5
`define SESQ_BIT_EXE 4
`define SESQ_BIT_DDE 3
`define SESQ_BIT_QYE 2
`define SESQ_BIT_OPC 0

// Bits 6 and 1 are never implemented and read as zero
`define SESQ_ESR_MASK 8'hbd

// Reset values
`define SESQ_ESR_RST 8'h00
`define SESQ_ESE_RST 8'h00

// Output queue depth in bytes, sized to match the level input
`define SESQ_OQ_DEPTH 9'h100
`define SESQ_OQ_EMPTY 9'h000

`endif

// *** core/sesq_pkg.sv ***
`default_nettype none

package sesq_pkg;

  // Power-on sequence phases
  typedef enum logic [1:0]
  {
    SESQ_RUN  = 2'b00,
    SESQ_PCLR = 2'b01,
    SESQ_PSET = 2'b10
  } sesq_phase_type;

  // One-cycle event pulses from the command engine
  typedef struct packed
  {
    logic cmdErr;
    logic exeErr;
    logic devErr;
    logic opDone;
  } sesq_event_type;

  // Complete state of the block
  typedef struct packed
  {
    sesq_phase_type phase;
    logic [7:0]     standard_event_status;
    logic [7:0]     standard_event_enable;
    logic           progRx;
    logic           respTx;
    logic           pwrS1;
    logic           pwrS2;
    logic           pwrS3;
    logic [7:0]     respData;
    logic           respValid;
    logic           inFlush;
    logic           outFlush;
    logic           respRestart;
    logic           esbSum;
  } sesq_state_type;

endpackage : sesq_pkg

`default_nettype wire

// *** tb/sesq_queue_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Far-side output queue as the bus controller leaves it: responses pile up
// until flushed or reset; the bench can jam it full to provoke overflow
module sesq_queue_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       respValid,
  input  wire logic       outFlush,
  input  wire logic       fillReq,
  output logic [8:0]      outLevel
);
  // Level saturates at the queue depth, never wraps past it
  always_ff @(posedge sys_clk)
  begin
    if (rst || outFlush)
      outLevel <= 9'h000;
    else if (fillReq)
      outLevel <= 9'h100;
    else if (respValid && outLevel != 9'h100)
      outLevel <= outLevel + 9'h001;
  end
endmodule : sesq_queue_model

`default_nettype wire

// *** tb/sesq_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module sesq_top_test;
  logic        sys_clk;
  logic        rst;
  logic        powerOn;
  logic        pscFlag;
  logic        pscImpl;
  logic [12:0] strb;
  logic [7:0]  eseValue;
  logic [3:0]  evSel;
  logic [8:0]  outLevel;
  logic [7:0]  respData;
  logic        respValid;
  logic        inFlush;
  logic        outFlush;
  logic        respRestart;
  logic        esbSummary;
  logic [7:0]  esrView;
  logic [2:0]  fl;
  logic        gotValid;
  int          mismatches;
  int          n_compared;
  int          cycles;
  sesq_pkg::sesq_event_type evIn;

  // One strobe bit per command, so a single task drives every kind;
  // the event strobe fires whichever sources evSel picks
  assign evIn = strb[11] ? evSel : 4'h0;

  sesq_top sesq_top_i
  (
    .sys_clk(sys_clk), .rst(rst), .powerOn(powerOn), .pscFlag(pscFlag),
    .pscImpl(pscImpl), .evIn(evIn), .progByte(strb[0]),
    .progTerm(strb[1]), .respByte(strb[2]), .respTerm(strb[3]),
    .talkAddr(strb[4]), .listenAddr(strb[5]), .queryRx(strb[6]),
    .outLevel(outLevel), .clsCmd(strb[7]), .esrQuery(strb[8]),
    .eseQuery(strb[9]), .eseWrite(strb[10]), .eseValue(eseValue),
    .respData(respData), .respValid(respValid), .inFlush(inFlush),
    .outFlush(outFlush), .respRestart(respRestart),
    .esbSummary(esbSummary), .esrView(esrView)
  );

  sesq_queue_model sesq_queue_model_i
  (
    .sys_clk(sys_clk), .rst(rst), .respValid(respValid),
    .outFlush(outFlush), .fillReq(strb[12]), .outLevel(outLevel)
  );

  // Free-running clock, 8 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Pulse one strobe for a cycle, then gather two cycles of answers
  // so either registered latency is caught
  task automatic pulse(input int k);
    @(posedge sys_clk);
    strb <= 13'h0001 << k;
    @(posedge sys_clk);
    strb <= 13'h0000;
    #1;
    fl = {inFlush, outFlush, respRestart};
    gotValid = respValid;
    @(posedge sys_clk);
    #1;
    fl = fl | {inFlush, outFlush, respRestart};
    gotValid = gotValid | respValid;
  endtask : pulse

  task automatic wr_ese(input logic [7:0] v);
    @(posedge sys_clk);
    eseValue <= v;
    pulse(10);
  endtask : wr_ese

  // One event source at a time, so a swapped bit position shows
  task automatic ev_one(input logic [3:0] s, input logic [7:0] e);
    @(posedge sys_clk);
    evSel <= s;
    pulse(11);
    chk("esr single event", e, esrView);
  endtask : ev_one

  task automatic power_up(input logic f, input logic i);
    @(posedge sys_clk);
    powerOn <= 1'b0;
    pscFlag <= f;
    pscImpl <= i;
    repeat (4) @(posedge sys_clk);
    powerOn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask : power_up

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    rst = 1'b1;
    powerOn = 1'b0;
    pscFlag = 1'b1;
    pscImpl = 1'b1;
    strb = 13'h0000;
    eseValue = 8'h00;
    evSel = 4'hf;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("esr after reset", 8'h00, esrView);
    // Power-on clears then records the power event; all four events latch
    power_up(1'b1, 1'b1);
    chk("esr power on", 8'h80, esrView);
    pulse(11);
    chk("esr all events", 8'hb9, esrView);
    $display("test power and events done");
    // Enable writes load the pattern, reads leave it, summary follows
    wr_ese(8'hff);
    chk("esr after enable write", 8'hb9, esrView);
    chk("summary on", 8'h01, {7'h00, esbSummary});
    pulse(9);
    chk("ese read", 8'hff, respData);
    pulse(9);
    chk("ese reread", 8'hff, respData);
    wr_ese(8'h42);
    chk("summary off", 8'h00, {7'h00, esbSummary});
    $display("test enable register done");
    pulse(8);
    chk("esr read", 8'hb9, respData);
    chk("esr read valid", 8'h01, {7'h00, gotValid});
    chk("esr cleared by read", 8'h00, esrView);
    // Sources one by one, each landing on its own bit and accumulating
    ev_one(4'h8, 8'h20);
    ev_one(4'h4, 8'h30);
    ev_one(4'h2, 8'h38);
    ev_one(4'h1, 8'h39);
    pulse(7);
    chk("esr cleared by cls", 8'h00, esrView);
    pulse(9);
    chk("ese kept by cls", 8'h42, respData);
    $display("test read and clear done");
    // Queue now holds unread answers; a new message drops them
    pulse(0);
    chk("drop flushes", 8'h03, {5'h00, fl & 3'b011});
    chk("drop no error", 8'h00, esrView);
    pulse(1);
    pulse(0);
    pulse(4);
    chk("talk abort flush", 8'h06, {5'h00, fl & 3'b110});
    chk("talk abort error", 8'h04, esrView);
    pulse(7);
    pulse(2);
    pulse(5);
    chk("listen abort flush", 8'h03, {5'h00, fl & 3'b011});
    chk("listen abort error", 8'h04, esrView);
    // A response whose terminator went out is no longer open to abort
    pulse(7);
    pulse(2);
    pulse(3);
    pulse(5);
    chk("listen after end flush", 8'h00, {5'h00, fl});
    chk("listen after end error", 8'h00, esrView);
    pulse(12);
    pulse(6);
    chk("overflow flush", 8'h03, {5'h00, fl & 3'b011});
    chk("overflow error", 8'h04, esrView);
    $display("test query errors done");
    wr_ese(8'h00);
    pulse(9);
    chk("ese zero", 8'h00, respData);
    // Power cycles without clear keep both registers, except ese when
    // the flag command is absent
    wr_ese(8'h55);
    power_up(1'b0, 1'b1);
    chk("esr kept at power", 8'h84, esrView);
    pulse(9);
    chk("ese kept at power", 8'h55, respData);
    power_up(1'b0, 1'b0);
    pulse(9);
    chk("ese cleared no cmd", 8'h00, respData);
    $display("test power flag done");
    tally_and_finish();
  end
endmodule : sesq_top_test

`default_nettype wire
